// *** rtl/eeprom_host_pkg.sv ***
// Package for the page-write host controller of a parallel EEPROM
package eeprom_host_pkg;
    localparam int          CLK_PERIOD_NS    = 5;
    // Pin timing in ns, counts derived (minimum times rounded up)
    localparam int          WP_NS            = 150;   // Strobe low width
    localparam int          AS_NS            = 10;    // Address setup
    localparam int          DS_NS            = 50;    // Data setup
    localparam int          RD_NS            = 200;   // Read access
    localparam int          GAP_NS           = 200;   // Least byte-load spacing (0.2 us)
    localparam int          BLW_MAX_NS       = 200000; // Byte-load window maximum (200 us)
    localparam int          WC_MAX_NS        = 10000000; // Internal write, at most 10 ms
    localparam logic [7:0]  WP_CYC           = 8'((WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  AS_CYC           = 8'((AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  DS_CYC           = 8'((DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  RD_CYC           = 8'((RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  GAP_CYC          = 8'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          BLW_MAX_CYC      = BLW_MAX_NS / CLK_PERIOD_NS;
    localparam int          WC_MAX_CYC       = WC_MAX_NS / CLK_PERIOD_NS;
    localparam int          PAGE_BYTES       = 64;
    localparam int          COL_W            = 6;
    localparam int          ROW_W            = 7;
    localparam int          TMR_W            = 24;

    // One write request from the user side
    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [7:0]       data;
        logic             last;   // Final byte of this page
    } wr_req_t;

    // Control pins toward the memory, all active low
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } ctl_pins_t;

    localparam ctl_pins_t   PINS_IDLE        = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

// *** rtl/cycle_timer.sv ***
// Loadable down-counter that flags when its count is used up
`timescale 1ns/10ps
module cycle_timer
#(
    parameter int W = 24
)
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    logic [W-1:0] cnt_q;

    assign done = (cnt_q == '0);

    // Load wins, else count down to zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= '0;
        else if (load)
            cnt_q <= value;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end
endmodule

// *** rtl/eeprom_page_write_control.sv ***
// Host-side controller that page-writes a parallel EEPROM and polls completion
// Functional notes
// - Strobe held low for minimum pulse width
// - Holding strobe low stretches page load
// - Host polls until true data returns
// - Polling read uses normal read timing
// - Host may poll ready/busy or ignore it
// - Loads spaced 0.2 us, window 200 us max (BLW_CYC is unused; the window is not bounded here)
// - Write: select low, output-enable high, strobe low
`timescale 1ns/10ps
module eeprom_page_write_control
#(
    parameter int BLW_CYC = eeprom_host_pkg::BLW_MAX_CYC,
    parameter int WC_CYC  = eeprom_host_pkg::WC_MAX_CYC
)
(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire eeprom_host_pkg::wr_req_t req,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    input  wire logic                     use_rdy,
    input  wire logic [7:0]               dq_in,
    input  wire logic                     rdy_busy_n,
    output logic [12:0]                   addr,
    output logic [7:0]                    dq_out,
    output logic                          dq_oe,
    output eeprom_host_pkg::ctl_pins_t    pins,
    output logic                          write_done,
    output logic                          write_timeout
);
    import eeprom_host_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_WAIT,
                              S_POLL_SET, S_POLL_RD, S_POLL_END} state_t;

    state_t             state_q;
    state_t             state_d;
    logic [7:0]         cnt_q;
    logic [ROW_W-1:0]   row_q;
    logic [7:0]         last_q;
    logic [COL_W-1:0]   lcol_q;
    logic [6:0]         nbytes_q;
    logic               last_flag_q;
    logic               ready_q;
    logic               done_q;
    logic               tout_q;
    logic [12:0]        addr_q;
    logic [7:0]         dout_q;
    logic               doe_q;
    ctl_pins_t          pins_q;
    logic               wc_load;
    logic               wc_done;
    wire                cnt_zero   = (cnt_q == 8'h00);
    wire                take       = (state_q == S_IDLE) && req_valid;
    wire                page_full  = (nbytes_q == 7'(PAGE_BYTES));
    wire                poll_match = (dq_in == last_q);
    wire                rdy_up     = use_rdy && rdy_busy_n;

    // Watchdog on the whole internal write
    cycle_timer #(.W(TMR_W)) u_wc (
        .clk    (clk),
        .resetn (resetn),
        .load   (wc_load),
        .value  (TMR_W'(WC_CYC)),
        .done   (wc_done)
    );

    // Reload as the hold after the last strobe rise ends: WC_CYC alone, no window time added
    assign wc_load = (state_q == S_HOLD) && cnt_zero && last_flag_q;

    // Next-state selection
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:     if (req_valid) state_d = S_SETUP;
            S_SETUP:    if (cnt_zero) state_d = S_STROBE;
            S_STROBE:   if (cnt_zero) state_d = S_HOLD;
            S_HOLD:     if (cnt_zero) state_d = last_flag_q ? S_WAIT : S_IDLE;
            S_WAIT:     if (cnt_zero) state_d = S_POLL_SET;
            S_POLL_SET: state_d = S_POLL_RD;
            S_POLL_RD:  if (cnt_zero) state_d = S_POLL_END;
            S_POLL_END:
            begin
                if (rdy_up || poll_match || wc_done) state_d = S_IDLE;
                else state_d = S_POLL_SET;
            end
            default:    state_d = S_IDLE;
        endcase
    end

    // State and phase counter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= S_IDLE;
            cnt_q   <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
            begin
                case (state_d)
                    S_SETUP:  cnt_q <= AS_CYC;
                    S_STROBE: cnt_q <= (WP_CYC > DS_CYC) ? WP_CYC : DS_CYC;
                    S_HOLD:   cnt_q <= GAP_CYC;
                    S_WAIT:   cnt_q <= GAP_CYC;
                    S_POLL_RD: cnt_q <= RD_CYC;
                    default:  cnt_q <= 8'h00;
                endcase
            end
            else if (!cnt_zero)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    // Page bookkeeping: the row stays fixed for the whole page
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            row_q       <= '0;
            last_q      <= 8'h00;
            lcol_q      <= '0;
            nbytes_q    <= 7'h00;
            last_flag_q <= 1'b0;
        end
        else if (take)
        begin
            if (nbytes_q == 7'h00)
                row_q <= req.row;
            last_q      <= req.data;
            lcol_q      <= req.col;
            nbytes_q    <= nbytes_q + 7'h01;
            last_flag_q <= req.last || (nbytes_q == 7'(PAGE_BYTES - 1));
        end
        else if (state_q == S_WAIT)
            nbytes_q <= 7'h00;
    end

    // Pin and status drive; writes never start until the poll of a settling page ends
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pins_q  <= PINS_IDLE;
            addr_q  <= 13'h0000;
            dout_q  <= 8'h00;
            doe_q   <= 1'b0;
            ready_q <= 1'b0;
            done_q  <= 1'b0;
            tout_q  <= 1'b0;
        end
        else
        begin
            done_q  <= 1'b0;
            tout_q  <= 1'b0;
            ready_q <= (state_d == S_IDLE) && !page_full;
            case (state_d)
                S_SETUP:
                begin
                    // Select low, output-enable high before the strobe
                    pins_q <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
                    addr_q <= take ? {(nbytes_q == 7'h00) ? req.row : row_q, req.col}
                                   : addr_q;
                    dout_q <= take ? req.data : dout_q;
                    doe_q  <= 1'b1;
                end
                // Fresh strobe fall for each byte; it latches address
                S_STROBE: pins_q <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
                // Strobe rise latches data, select released after
                S_HOLD:   pins_q <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
                S_POLL_SET:
                begin
                    // Ordinary read of the last address
                    pins_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                    addr_q <= {row_q, lcol_q};
                    doe_q  <= 1'b0;
                end
                // Read held through the sampling cycle so the bus still carries data
                S_POLL_RD, S_POLL_END: pins_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                default:
                begin
                    pins_q <= PINS_IDLE;
                    doe_q  <= 1'b0;
                end
            endcase
            if (state_q == S_POLL_END && state_d == S_IDLE)
            begin
                done_q <= 1'b1;
                tout_q <= wc_done && !poll_match && !rdy_up;
            end
        end
    end

    assign req_ready     = ready_q;
    assign addr          = addr_q;
    assign dq_out        = dout_q;
    assign dq_oe         = doe_q;
    assign pins          = pins_q;
    assign write_done    = done_q;
    assign write_timeout = tout_q;

    // Write strobe only with select low and output-enable high
    strobe_state_a: assert property (@(posedge clk) disable iff (!resetn)
        !pins_q.we_n |-> (!pins_q.ce_n && pins_q.oe_n))
        else $error("strobe outside write state");

    // Strobe low at least 16 cycles (80 ns), less than the 150 ns pulse width
    strobe_width_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(pins_q.we_n) |-> !pins_q.we_n [*8] ##1 !pins_q.we_n [*8])
        else $error("strobe pulse too short");

    // Data bus released during reads
    read_bus_a: assert property (@(posedge clk) disable iff (!resetn)
        !pins_q.oe_n |-> !doe_q)
        else $error("data driven during read");

    // Data steady while strobe is low
    data_steady_a: assert property (@(posedge clk) disable iff (!resetn)
        (!pins_q.we_n && !$past(pins_q.we_n)) |-> $stable(dout_q))
        else $error("data moved under strobe");

    // Row fixed across a page
    row_fixed_a: assert property (@(posedge clk) disable iff (!resetn)
        (take && nbytes_q != 7'h00) |=> (addr_q[12:6] == row_q))
        else $error("row changed within page");

    // Never more than a page of loads
    page_limit_a: assert property (@(posedge clk) disable iff (!resetn)
        nbytes_q <= 7'(PAGE_BYTES))
        else $error("page overflow");

    // No load offered while waiting on the write
    busy_block_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q inside {S_WAIT, S_POLL_SET, S_POLL_RD, S_POLL_END}) |-> !req_ready)
        else $error("load accepted during write");

    // Polling read addresses the last byte written
    poll_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == S_POLL_RD) |-> (addr_q == {row_q, lcol_q}))
        else $error("poll at wrong address");
endmodule

// *** verif/eeprom_model.sv ***
// Behavioural parallel EEPROM: page buffer, window timer, polling data, open-drain busy
`timescale 1ns/10ps
module eeprom_model
#(
    parameter int BLW = 100
)
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [12:0]                addr,
    input  wire logic [7:0]                 dq_out,
    input  wire logic                       dq_oe,
    input  wire eeprom_host_pkg::ctl_pins_t pins,
    input  wire logic                       slow,
    output logic [7:0]                      dq_in,
    output logic                            rdy_busy_n
);
    import eeprom_host_pkg::*;
    logic [7:0]  mem [0:8191];
    logic [7:0]  page_q [0:63];
    logic [63:0] used_q;
    logic [7:0]  last_q;
    logic [7:0]  float_q;
    logic [6:0]  row_q;
    logic [5:0]  col_q;
    logic [15:0] tmr_q;
    logic [15:0] low_q;
    logic        load_q;
    logic        busy_q;
    logic        weprev_q;
    logic        rowset_q;
    logic        sink_q;
    // Pin decode; a strobe shorter than four cycles is noise
    wire         wr_st  = !pins.ce_n && pins.oe_n && !busy_q;
    wire         rd_st  = !pins.ce_n && !pins.oe_n && pins.we_n;
    wire         rise   = !weprev_q && pins.we_n && low_q >= 16'h4;
    wire [15:0]  wc_len = slow ? 16'hbb8 : 16'h96;
    wire [7:0]   rd_val = (load_q || busy_q) ? ~last_q : mem[addr];
    // Data seen on a strobe rise; an undriven bus gives noise, not the host byte
    wire [7:0]   bus_wr = dq_oe ? dq_out : float_q;
    // Read drive; a released bus toggles so stale data cannot pass
    assign dq_in      = rd_st ? rd_val : float_q;
    assign rdy_busy_n = !sink_q; // Sinks only, the pull-up gives high
    // Load, window timer and internal write
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            weprev_q <= 1'b1; // A fresh strobe fall is needed
            load_q   <= 1'b0;
            busy_q   <= 1'b0;
            sink_q   <= 1'b0;
            rowset_q <= 1'b0;
            used_q   <= '0;
            low_q    <= '0;
            tmr_q    <= '0;
            float_q  <= 8'h00;
        end
        else
        begin
            weprev_q <= pins.we_n;
            float_q  <= ~dq_in;
            low_q    <= (wr_st && !pins.we_n) ? low_q + 16'h1 : '0;
            if (wr_st && !pins.we_n)
            begin
                tmr_q  <= '0; // Held clear while strobe low
                sink_q <= 1'b1;
                if (weprev_q)
                begin
                    col_q <= addr[5:0];
                    if (!rowset_q)
                        row_q <= addr[12:6];
                end
            end
            else if (rise)
            begin
                page_q[col_q] <= bus_wr;
                used_q[col_q] <= 1'b1;
                last_q        <= bus_wr;
                rowset_q      <= 1'b1;
                load_q        <= 1'b1;
                tmr_q         <= 16'h1;
            end
            else if (load_q || busy_q)
            begin
                tmr_q <= tmr_q + 16'h1;
                if (load_q && tmr_q == 16'(BLW))
                begin
                    load_q <= 1'b0; // Window over, internal write
                    busy_q <= 1'b1;
                    tmr_q  <= '0;
                    for (int i = 0; i < 64; i++)
                        if (used_q[i])
                            mem[{row_q, 6'(i)}] <= page_q[i];
                end
                if (busy_q && tmr_q == wc_len)
                begin
                    busy_q   <= 1'b0;
                    sink_q   <= 1'b0;
                    rowset_q <= 1'b0;
                    used_q   <= '0;
                end
            end
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench of the page-write controller against the EEPROM model
`timescale 1ns/10ps
module testbench;
    import eeprom_host_pkg::*;
    logic        clk;
    logic        resetn;
    logic        req_valid;
    logic        req_ready;
    logic        use_rdy;
    logic        slow;
    logic        dq_oe;
    logic        rdy_busy_n;
    logic        write_done;
    logic        write_timeout;
    logic [7:0]  dq_in;
    logic [7:0]  dq_out;
    logic [12:0] addr;
    wr_req_t     req;
    ctl_pins_t   pins;
    int          fail_count;
    int          checks;
    int          cycles = 0;
    // Controller with short watchdog; its BLW_CYC window setting is unused
    eeprom_page_write_control #(.BLW_CYC(100), .WC_CYC(400)) i_dut
    (
        .clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .use_rdy(use_rdy), .dq_in(dq_in), .rdy_busy_n(rdy_busy_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins), .write_done(write_done),
        .write_timeout(write_timeout)
    );
    // Memory on the far side
    eeprom_model #(.BLW(100)) i_mem
    (
        .clk(clk), .resetn(resetn), .addr(addr), .dq_out(dq_out), .pins(pins),
        .slow(slow), .dq_oe(dq_oe), .dq_in(dq_in), .rdy_busy_n(rdy_busy_n)
    );
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cycle ceiling against hangs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fail_count = fail_count + 1;
            test_done();
        end
    end
    task automatic test_done();
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Present one byte and hold it until taken
    task automatic send(input logic [6:0] r, input logic [5:0] c, input logic [7:0] d,
                        input logic l);
        req       = '{row: r, col: c, data: d, last: l};
        req_valid = 1'b1;
        @(posedge clk);
        while (req_ready !== 1'b1)
            @(posedge clk);
        #1 req_valid = 1'b0;
        // Let an edge pass so the next request never re-raises valid in this step
        @(posedge clk);
        #1;
    endtask
    // Wait for the end-of-write pulse and judge the timeout flag
    task automatic wait_done(input logic to);
        int n;
        n = 0;
        while (write_done !== 1'b1 && n < 6000)
        begin
            @(posedge clk);
            n++;
        end
        checks++;
        if (write_done !== 1'b1 || write_timeout !== to)
        begin
            $display("wrong value at %0t: write end or timeout flag", $time);
            fail_count++;
        end
        #1;
    endtask
    task automatic chk_mem(input logic [12:0] a, input logic [7:0] d);
        checks++;
        if (i_mem.mem[a] !== d)
        begin
            $display("wrong value at %0t: stored byte at %h", $time, a);
            fail_count++;
        end
    endtask
    task automatic chk_rdy(input logic v);
        checks++;
        if (rdy_busy_n !== v)
        begin
            $display("wrong value at %0t: ready/busy line", $time);
            fail_count++;
        end
    endtask
    // One byte ended by data polling
    task automatic t_single();
        send(7'h05, 6'h03, 8'ha5, 1'b1);
        repeat (20) @(posedge clk);
        chk_rdy(1'b0);
        wait_done(1'b0);
        chk_mem(13'h0143, 8'ha5);
        chk_rdy(1'b1);
    endtask
    // Full page, reverse columns, later rows differ except byte 9, ended by the count
    task automatic t_page();
        for (int i = 0; i < 64; i++)
            send(i == 0 ? 7'h09 : 7'(i), 6'(63 - i), 8'(3 * i + 1), 1'b0);
        wait_done(1'b0);
        for (int i = 0; i < 64; i++)
            chk_mem({7'h09, 6'(63 - i)}, 8'(3 * i + 1));
    endtask
    // Completion taken from the ready line
    task automatic t_rdy();
        use_rdy = 1'b1;
        send(7'h7f, 6'h3f, 8'h3c, 1'b1);
        wait_done(1'b0);
        chk_mem(13'h1fff, 8'h3c);
        use_rdy = 1'b0;
    endtask
    // Internal write longer than the watchdog
    task automatic t_slow();
        slow = 1'b1;
        send(7'h40, 6'h00, 8'h5a, 1'b1);
        wait_done(1'b1);
        repeat (3200) @(posedge clk);
        chk_mem(13'h1000, 8'h5a);
        chk_rdy(1'b1);
        #1 slow = 1'b0;
    endtask
    // Main sequence
    initial
    begin
        resetn     = 1'b0;
        req_valid  = 1'b0;
        req        = '0;
        use_rdy    = 1'b0;
        slow       = 1'b0;
        fail_count = 0;
        checks     = 0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_single();
        t_page();
        t_rdy();
        t_slow();
        test_done();
    end
endmodule
